// ---- core/nrib_top.sv ----
`timescale 1ns/1ps
module nrib_top (
  input  wire logic              clock_in,
  input  wire logic              srst_in,
  input  wire logic              soft_reset_in,
  input  wire logic              bus_wr_in,
  input  wire logic              bus_rd_in,
  input  wire logic [2:0]        bus_addr_in,
  input  wire logic [7:0]        bus_wdata_in,
  output logic      [7:0]        bus_rdata_out,
  input  wire nrib_pkg::nrib_seq_t seq_in,
  output logic                   irq_out,
  output logic                   core_awake_out,
  output logic                   ring_join_out,
  output logic      [7:0]        command_out,
  output logic                   command_valid_out,
  output logic      [7:0]        config_out,
  output logic      [7:0]        setup_out
);
  nrib_pkg::nrib_bus_t bus;
  assign bus = '{wr: bus_wr_in, rd: bus_rd_in, addr: bus_addr_in, wdata: bus_wdata_in};

  logic [7:0]  mask_reg, config_reg, probe_reg, own_reg, setup_reg, succ_reg;
  logic [7:0]  ptr_hi_reg, ptr_lo_reg, data_reg, rdata_reg, cmd_reg;
  logic [10:0] ram_addr_reg;
  logic        cmd_valid_reg;
  logic        ri_reg, por_reg, reconfiguration_flag_reg, tma_reg, ta_reg;
  logic [7:0]  diag_reg;
  logic [7:0]  ram_mem [nrib_pkg::RAM_DEPTH];

  function automatic logic hit(input nrib_pkg::nrib_bus_t b, input logic [2:0] a);
    hit = b.addr == a;
  endfunction

  wire [1:0] subsel   = config_reg[1:0];
  wire       any_rst  = srst_in | soft_reset_in;
  wire       wr_mask  = bus.wr && hit(bus, nrib_pkg::ADR_STATUS);
  wire       wr_cmd   = bus.wr && hit(bus, nrib_pkg::ADR_DIAG);
  wire       wr_phi   = bus.wr && hit(bus, nrib_pkg::ADR_PTR_HI);
  wire       wr_plo   = bus.wr && hit(bus, nrib_pkg::ADR_PTR_LO);
  wire       wr_data  = bus.wr && hit(bus, nrib_pkg::ADR_DATA);
  wire       wr_cfg   = bus.wr && hit(bus, nrib_pkg::ADR_CONFIG);
  wire       wr_sub   = bus.wr && hit(bus, nrib_pkg::ADR_SUB);
  wire       rd_diag  = bus.rd && hit(bus, nrib_pkg::ADR_DIAG);
  wire       rd_data  = bus.rd && hit(bus, nrib_pkg::ADR_DATA);
  wire       rd_succ  = bus.rd && hit(bus, nrib_pkg::ADR_SUB) && subsel == nrib_pkg::SUB_SUCC;
  wire       clr_cmd  = wr_cmd && bus.wdata == nrib_pkg::CMD_CLR_FLAGS;
  wire       por_cmd  = wr_cmd && bus.wdata == nrib_pkg::CMD_POR_CLR_FLAGS;
  wire       awake    = own_reg != nrib_pkg::ID_RST;
  wire       own_zero = wr_sub && subsel == nrib_pkg::SUB_OWN && bus.wdata == nrib_pkg::ID_RST;
  wire [10:0] new_addr = {ptr_hi_reg[2:0], bus.wdata};
  wire       probe_hit = awake && seq_in.node_seen && seq_in.node_seen_id == probe_reg;
  wire       succ_upd  = awake && seq_in.succ_update;

  wire [7:0] status_view = {ri_reg, 2'b00, por_reg, 1'b0, reconfiguration_flag_reg, tma_reg, ta_reg};
  wire [7:0] flags_view  = status_view | diag_reg;
  // status and diagnostic overlap on bits 1 and 2; irq takes bit 2 from status and bit 1 from diagnostic
  wire [7:0] irq_src = {ri_reg, 3'b000, diag_reg[nrib_pkg::BIT_EXCESSIVE_NAK_FLAG], reconfiguration_flag_reg,
                        diag_reg[nrib_pkg::BIT_NEWSUCC], ta_reg};
  assign irq_out = |(irq_src & mask_reg & nrib_pkg::MASK_VALID);

  wire [7:0] sub_rd = (subsel == nrib_pkg::SUB_PROBE) ? probe_reg :
                      (subsel == nrib_pkg::SUB_OWN)   ? own_reg :
                      (subsel == nrib_pkg::SUB_SETUP) ? setup_reg : succ_reg;
  wire [7:0] rd_mux = hit(bus, nrib_pkg::ADR_STATUS) ? status_view :
                      hit(bus, nrib_pkg::ADR_DIAG)   ? diag_reg :
                      hit(bus, nrib_pkg::ADR_PTR_HI) ? ptr_hi_reg :
                      hit(bus, nrib_pkg::ADR_PTR_LO) ? ptr_lo_reg :
                      hit(bus, nrib_pkg::ADR_DATA)   ? data_reg :
                      hit(bus, nrib_pkg::ADR_CONFIG) ? config_reg :
                      hit(bus, nrib_pkg::ADR_SUB)    ? sub_rd : 8'h00;

  assign bus_rdata_out     = rdata_reg;
  assign core_awake_out    = awake;
  assign ring_join_out     = awake && config_reg[nrib_pkg::BIT_TXJOIN];
  assign command_out       = cmd_reg;
  assign command_valid_out = cmd_valid_reg;
  assign config_out        = config_reg;
  assign setup_out         = setup_reg;

  // hardware-reset-only registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      mask_reg   <= nrib_pkg::MASK_RST;
      config_reg <= nrib_pkg::CONFIG_RST;
      probe_reg  <= nrib_pkg::ID_RST;
      own_reg    <= nrib_pkg::ID_RST;
      setup_reg  <= nrib_pkg::SETUP_RST;
      ptr_hi_reg <= 8'h00;
      ptr_lo_reg <= 8'h00;
    end else begin
      if (wr_mask) mask_reg <= bus.wdata & nrib_pkg::MASK_VALID;
      if (wr_cfg) config_reg <= bus.wdata;
      if (wr_sub && subsel == nrib_pkg::SUB_PROBE) probe_reg <= bus.wdata;
      if (wr_sub && subsel == nrib_pkg::SUB_OWN) own_reg <= bus.wdata;
      if (wr_sub && subsel == nrib_pkg::SUB_SETUP) setup_reg <= bus.wdata;
      if (wr_phi) ptr_hi_reg <= bus.wdata & nrib_pkg::PTR_HI_MASK;
      if (wr_plo) ptr_lo_reg <= bus.wdata;
    end
  end

  // ram path: address applied on low write, data port prefetched once
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ram_addr_reg <= 11'h000;
      data_reg     <= 8'h00;
      rdata_reg    <= 8'h00;
    end else begin
      rdata_reg <= bus.rd ? rd_mux : 8'h00;
      if (wr_plo) begin
        ram_addr_reg <= new_addr;
        data_reg     <= ram_mem[new_addr];
      end else if (wr_data) begin
        data_reg <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (wr_data) ram_mem[ram_addr_reg] <= bus.wdata;
  end

  // flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (any_rst) begin
      ri_reg        <= 1'b1;
      por_reg       <= 1'b1;
      reconfiguration_flag_reg     <= 1'b0;
      tma_reg       <= 1'b0;
      ta_reg        <= 1'b1;
      diag_reg      <= nrib_pkg::DIAG_RST;
      succ_reg      <= nrib_pkg::ID_RST;
      cmd_reg       <= 8'h00;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= wr_cmd;
      if (wr_cmd) cmd_reg <= bus.wdata;
      if (seq_in.rx_deposited) ri_reg <= 1'b1;
      else if (seq_in.rx_enable_cmd) ri_reg <= 1'b0;
      if (seq_in.tx_done || seq_in.tx_disable) ta_reg <= 1'b1;
      else if (seq_in.tx_enable_cmd) ta_reg <= 1'b0;
      if (seq_in.tx_acked) tma_reg <= 1'b1;
      else if (seq_in.tx_enable_cmd) tma_reg <= 1'b0;
      if (awake && seq_in.reconfiguration_flag_seen) reconfiguration_flag_reg <= 1'b1;
      else if (clr_cmd || por_cmd) reconfiguration_flag_reg <= 1'b0;
      if (own_zero) por_reg <= 1'b1;
      else if (clr_cmd || por_cmd) por_reg <= 1'b0;
      if (succ_upd) succ_reg <= seq_in.succ_id;
      diag_reg[7] <= seq_in.my_reconfiguration_flag | (diag_reg[7] & ~rd_diag);
      diag_reg[6] <= seq_in.dup_id | (diag_reg[6] & ~rd_diag);
      diag_reg[5] <= seq_in.rcv_active | (diag_reg[5] & ~rd_diag);
      diag_reg[4] <= seq_in.token_seen | (diag_reg[4] & ~rd_diag);
      diag_reg[nrib_pkg::BIT_EXCESSIVE_NAK_FLAG] <= seq_in.excess_nak |
          (diag_reg[nrib_pkg::BIT_EXCESSIVE_NAK_FLAG] & ~por_cmd);
      diag_reg[nrib_pkg::BIT_PROBE] <= probe_hit |
          (diag_reg[nrib_pkg::BIT_PROBE] & ~rd_diag);
      diag_reg[nrib_pkg::BIT_NEWSUCC] <= succ_upd |
          (diag_reg[nrib_pkg::BIT_NEWSUCC] & ~rd_succ);
      diag_reg[0] <= 1'b0;
    end
  end

  a_irq_gate: assert property (@(posedge clock_in) disable iff (srst_in)
    irq_out == |({ri_reg, diag_reg[3], reconfiguration_flag_reg, diag_reg[1], ta_reg} &
                 {mask_reg[7], mask_reg[3:0]}))
    else $error("interrupt not equal to masked flags");
  a_mask_restore: assert property (@(posedge clock_in) disable iff (srst_in)
    (ri_reg && mask_reg[7]) |-> irq_out)
    else $error("enabled receive flag without interrupt");
  a_reconfiguration_flag_clear: assert property (@(posedge clock_in) disable iff (any_rst)
    (clr_cmd && !seq_in.reconfiguration_flag_seen) |=> !reconfiguration_flag_reg)
    else $error("reconfiguration flag survived clear");
  a_excessive_nak_flag_hold: assert property (@(posedge clock_in) disable iff (any_rst)
    (diag_reg[3] && !por_cmd) |=> diag_reg[3])
    else $error("excessive nak flag lost");
  a_succ_clear: assert property (@(posedge clock_in) disable iff (any_rst)
    (rd_succ && !succ_upd) |=> !diag_reg[1])
    else $error("successor flag not cleared");
  a_succ_set: assert property (@(posedge clock_in) disable iff (any_rst)
    succ_upd |=> diag_reg[1] && succ_reg == $past(seq_in.succ_id))
    else $error("successor update missing");
  a_ptr_apply: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_plo |=> ram_addr_reg == $past(new_addr))
    else $error("pointer not applied");
  a_diag_rdclr: assert property (@(posedge clock_in) disable iff (any_rst)
    (rd_diag && !seq_in.dup_id) |=> !diag_reg[6])
    else $error("diagnostic bit not cleared");
  a_sleep_join: assert property (@(posedge clock_in) disable iff (srst_in)
    (own_reg == 8'h00) |-> !ring_join_out && !probe_hit)
    else $error("asleep core active");
  a_status_rst: assert property (@(posedge clock_in)
    $past(any_rst) |-> status_view == 8'h91)
    else $error("status reset value wrong");
endmodule

// ---- shared/nrib_pkg.sv ----
// Summary of operation
// - interrupt is the OR of five flags (three status, two diagnostic) each ANDed with its mask bit
// - mask bits share positions with the flags they gate; one enables
// - only five flags can raise the interrupt; all other bits never do
// - clearing a receive or transmit mask hides it; setting it restores
// - clear-flags command clears the reconfiguration flag and its interrupt
// - excessive nak flag clears only by power-on clear command or reset
// - reading the successor register clears the successor changed flag
// - two subaddress bits select which register sits at location seven
// - data port reads and writes ram at the current pointer location
// - data port is loaded from ram once per pointer low byte write
// - probe id seen on network while the core is awake sets the probe found diagnostic flag
// - core stays asleep while own node id is zero
// - awake core stays off the ring until transmit join enable is set
// - own node id clears on hardware reset only
// - successor register holds the token successor, updated by sequencer
// - every successor update sets the successor changed flag
// - successor register clears on hardware or software reset
// - status reads 1xx1 0001 after either reset
// - diagnostic read clears all bits except excessive nak and successor changed
// - diagnostic register reads 0000 000x after either reset
// - pointer high is written first; the address takes effect on low write
// - receive inhibited sets once a message lands in the enabled page
// - transmitter available sets after last byte sent or on disable
package nrib_pkg;
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 8;
  localparam int          RAM_AW       = 11;
  localparam int          RAM_DEPTH    = 2048;
  localparam logic [2:0]  ADR_STATUS   = 3'h0;
  localparam logic [2:0]  ADR_DIAG     = 3'h1;
  localparam logic [2:0]  ADR_PTR_HI   = 3'h2;
  localparam logic [2:0]  ADR_PTR_LO   = 3'h3;
  localparam logic [2:0]  ADR_DATA     = 3'h4;
  localparam logic [2:0]  ADR_CONFIG   = 3'h6;
  localparam logic [2:0]  ADR_SUB      = 3'h7;
  localparam logic [1:0]  SUB_PROBE    = 2'h0;
  localparam logic [1:0]  SUB_OWN      = 2'h1;
  localparam logic [1:0]  SUB_SETUP    = 2'h2;
  localparam logic [1:0]  SUB_SUCC     = 2'h3;
  // flag bit positions, shared by status, diagnostic and mask; BIT_TXJOIN is a config bit
  localparam int          BIT_RI       = 7;
  localparam int          BIT_POR      = 4;
  localparam int          BIT_EXCESSIVE_NAK_FLAG   = 3;
  localparam int          BIT_RECONFIGURATION_FLAG    = 2;
  localparam int          BIT_TMA      = 1;
  localparam int          BIT_NEWSUCC  = 1;
  localparam int          BIT_PROBE    = 2;
  localparam int          BIT_TA       = 0;
  localparam int          BIT_TXJOIN   = 5;
  localparam logic [7:0]  MASK_VALID   = 8'h9f;
  localparam logic [7:0]  PTR_HI_MASK  = 8'hc7;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [7:0]  CONFIG_RST   = 8'h18;
  localparam logic [7:0]  ID_RST       = 8'h00;
  localparam logic [7:0]  SETUP_RST    = 8'h00;
  localparam logic [7:0]  DIAG_RST     = 8'h00;
  localparam logic [7:0]  DIAG_KEEP    = 8'h0a;
  // command codes for flag clearing, chosen values
  localparam logic [7:0]  CMD_CLR_FLAGS     = 8'h1e;
  localparam logic [7:0]  CMD_POR_CLR_FLAGS = 8'h0e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } nrib_bus_t;

  typedef struct packed {
    logic       rx_deposited;
    logic       tx_done;
    logic       tx_disable;
    logic       tx_enable_cmd;
    logic       rx_enable_cmd;
    logic       tx_acked;
    logic       reconfiguration_flag_seen;
    logic       my_reconfiguration_flag;
    logic       dup_id;
    logic       rcv_active;
    logic       token_seen;
    logic       excess_nak;
    logic       node_seen;
    logic [7:0] node_seen_id;
    logic       succ_update;
    logic [7:0] succ_id;
  } nrib_seq_t;
endpackage

// ---- testbench/nrib_host.sv ----
`timescale 1ns/1ps
module nrib_host (
  input  wire logic       clock_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [2:0]      addr_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in
);
  initial begin
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = 3'h5;
    wdata_out = 8'h5a;
  end
  // a released bus shows the inverse of its last value, so stale data never matches
  task automatic w(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge clock_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic r(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_in);
    rd_out   <= 1'b1;
    addr_out <= a;
    @(posedge clock_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(negedge clock_in);
    d = rdata_in;
  endtask
  task automatic cmd(input logic [7:0] code);
    w(3'h1, code);
  endtask
  task automatic ptr(input logic [7:0] hi, input logic [7:0] lo);
    w(3'h2, hi);
    w(3'h3, lo);
  endtask
endmodule

// ---- testbench/nrib_top_test.sv ----
`timescale 1ns/1ps
module nrib_top_test;
  logic                clock_in      = 1'b0;
  logic                srst_in       = 1'b1;
  logic                soft_reset_in = 1'b0;
  nrib_pkg::nrib_seq_t seq_in        = '0;
  logic                bus_wr;
  logic                bus_rd;
  logic [2:0]          bus_addr;
  logic [7:0]          bus_wdata;
  logic [7:0]          bus_rdata;
  logic                irq;
  logic                awake;
  logic                ring_join;
  logic [7:0]          q;
  logic [7:0]          cmd_seen;
  logic                cmd_strobe;
  logic [7:0]          cfg_seen;
  logic [7:0]          setup_seen;
  int                  err_total     = 0;
  int                  num_checks    = 0;
  always #25 clock_in = ~clock_in;
  nrib_top nrib_top_i (.clock_in(clock_in), .srst_in(srst_in), .soft_reset_in(soft_reset_in),
    .bus_wr_in(bus_wr), .bus_rd_in(bus_rd), .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata),
    .bus_rdata_out(bus_rdata), .seq_in(seq_in), .irq_out(irq), .core_awake_out(awake),
    .ring_join_out(ring_join), .command_out(cmd_seen), .command_valid_out(cmd_strobe),
    .config_out(cfg_seen), .setup_out(setup_seen));
  nrib_host nrib_host_i (.clock_in(clock_in), .wr_out(bus_wr), .rd_out(bus_rd),
    .addr_out(bus_addr), .wdata_out(bus_wdata), .rdata_in(bus_rdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] d);
    nrib_host_i.w(a, d);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    nrib_host_i.r(a, q);
    chk(q, exp);
  endtask
  task automatic ci(input logic exp);
    @(negedge clock_in);
    chk({7'h00, irq}, {7'h00, exp});
  endtask
  task automatic ev(input nrib_pkg::nrib_seq_t s);
    @(posedge clock_in);
    seq_in <= s;
    @(posedge clock_in);
    seq_in <= '0;
  endtask
  task automatic hw_reset;
    @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
  endtask
  task automatic test_done;
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset;
    rc(3'h0, 8'h91);
    rc(3'h1, 8'h00);
    rc(3'h6, 8'h18);
    rc(3'h7, 8'h00);
    rc(3'h5, 8'h00);
    ci(1'b0);
    chk({7'h00, awake}, 8'h00);
  endtask
  task automatic t_mask;
    w(3'h0, 8'h70);
    ci(1'b0);
    w(3'h0, 8'h01);
    ci(1'b1);
    w(3'h0, 8'h00);
    ci(1'b0);
    w(3'h0, 8'h01);
    ci(1'b1);
    ev('{tx_enable_cmd: 1'b1, default: '0});
    ci(1'b0);
    ev('{tx_disable: 1'b1, default: '0});
    ci(1'b1);
    w(3'h0, 8'h80);
    ci(1'b1);
    ev('{rx_enable_cmd: 1'b1, default: '0});
    ci(1'b0);
    ev('{rx_deposited: 1'b1, default: '0});
    ci(1'b1);
  endtask
  task automatic t_reconfiguration_flag;
    // the core must be awake before it can see a reconfiguration
    w(3'h6, 8'h19);
    w(3'h7, 8'h07);
    w(3'h6, 8'h18);
    w(3'h0, 8'h04);
    ev('{reconfiguration_flag_seen: 1'b1, default: '0});
    ci(1'b1);
    nrib_host_i.cmd(8'h1e);
    @(negedge clock_in);
    chk(cmd_seen, 8'h1e);
    chk({7'h00, cmd_strobe}, 8'h01);
    ci(1'b0);
  endtask
  task automatic t_diag;
    w(3'h7, 8'h33);
    ev('{node_seen: 1'b1, node_seen_id: 8'h34, default: '0});
    ev('{node_seen: 1'b1, node_seen_id: 8'h33, dup_id: 1'b1, excess_nak: 1'b1, default: '0});
    w(3'h0, 8'h08);
    rc(3'h1, 8'h4c);
    rc(3'h1, 8'h08);
    ci(1'b1);
    nrib_host_i.cmd(8'h1e);
    ci(1'b1);
    nrib_host_i.cmd(8'h0e);
    ci(1'b0);
  endtask
  task automatic t_succ;
    w(3'h6, 8'h1b);
    w(3'h0, 8'h02);
    ev('{succ_update: 1'b1, succ_id: 8'h5a, default: '0});
    ci(1'b1);
    rc(3'h1, 8'h02);
    w(3'h7, 8'hff);
    rc(3'h7, 8'h5a);
    ci(1'b0);
  endtask
  task automatic t_node;
    w(3'h6, 8'h19);
    w(3'h7, 8'h07);
    rc(3'h7, 8'h07);
    chk({6'h00, awake, ring_join}, 8'h02);
    w(3'h6, 8'h39);
    @(negedge clock_in);
    chk({6'h00, awake, ring_join}, 8'h03);
    @(posedge clock_in);
    soft_reset_in <= 1'b1;
    @(posedge clock_in);
    soft_reset_in <= 1'b0;
    rc(3'h7, 8'h07);
    rc(3'h0, 8'h91);
    rc(3'h1, 8'h00);
    w(3'h6, 8'h1a);
    w(3'h7, 8'h5c);
    @(negedge clock_in);
    chk(setup_seen, 8'h5c);
    chk(cfg_seen, 8'h1a);
    w(3'h6, 8'h1b);
    rc(3'h7, 8'h00);
    hw_reset;
    w(3'h6, 8'h19);
    rc(3'h7, 8'h00);
  endtask
  task automatic t_ram;
    nrib_host_i.ptr(8'h05, 8'ha7);
    w(3'h4, 8'hc3);
    nrib_host_i.ptr(8'h05, 8'ha8);
    w(3'h4, 8'h3c);
    // a lone high write must leave the live address alone
    w(3'h2, 8'h06);
    w(3'h4, 8'h77);
    nrib_host_i.ptr(8'h05, 8'ha7);
    rc(3'h4, 8'hc3);
    nrib_host_i.ptr(8'h05, 8'ha8);
    rc(3'h4, 8'h77);
  endtask
  initial begin
    hw_reset;
    t_reset;
    t_mask;
    t_reconfiguration_flag;
    t_diag;
    t_succ;
    t_node;
    t_ram;
    test_done;
  end
endmodule
